/* verilog/mbs_pkg.sv */
/*
  mbs_pkg: constants, state type and byte carrier for the
  serial-link command handler of the four-channel alarm unit.
  assumes: one clock domain; byte stream framed by an external uart.
*/
package mbs_pkg;

  // function codes
  localparam logic [7:0] FN_READ_BIT   = 8'h01;
  localparam logic [7:0] FN_READ_WORD  = 8'h03;
  localparam logic [7:0] FN_WRITE_BIT  = 8'h05;
  localparam logic [7:0] FN_WRITE_WORD = 8'h06;

  // unit numbers and field values
  localparam logic [7:0] BCAST_UNIT = 8'h00;
  localparam logic [7:0] ADDR_HIGH  = 8'h00;
  localparam logic [7:0] COUNT_HIGH = 8'h00;
  localparam logic [7:0] COUNT_LOW  = 8'h01;
  localparam logic [7:0] COIL_ON    = 8'hff;
  localparam logic [7:0] COIL_OFF   = 8'h00;
  localparam logic [7:0] COIL_PAD   = 8'h00;
  localparam logic [7:0] BIT_BYTES  = 8'h01;
  localparam logic [7:0] WORD_BYTES = 8'h02;

  // bit map: red, amber, green leds, then alarm, warn, ok relays
  localparam int unsigned COIL_COUNT = 25;
  localparam int unsigned CHAN_COUNT = 4;

  // word register offsets
  localparam logic [7:0] CH1_READING_OFS = 8'h00;
  localparam logic [7:0] CH2_READING_OFS = 8'h01;
  localparam logic [7:0] CH3_READING_OFS = 8'h02;
  localparam logic [7:0] CH4_READING_OFS = 8'h03;

  // reset values
  localparam logic [15:0] READING_RST = 16'h0000;
  localparam logic        COIL_RST    = 1'b0;

  // frame layout and check
  localparam logic [3:0]  FRAME_LEN    = 4'h8;
  localparam logic [3:0]  RD_BIT_DATA  = 4'h4;
  localparam logic [3:0]  RD_WORD_DATA = 4'h5;
  localparam logic [3:0]  RD_BIT_LEN   = 4'h6;
  localparam logic [3:0]  RD_WORD_LEN  = 4'h7;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE  = 16'h0000;

  typedef enum logic [0:0] {MBS_RX, MBS_TX} mbs_state_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mbs_byte_s;

endpackage

/* verilog/mbs_crc_step.sv */
/*
  mbs_crc_step: one byte of the reflected crc-16 update.
  assumes: caller holds the running value in its own register.
*/
`timescale 1ns/1ns
`default_nettype none
module mbs_crc_step
  import mbs_pkg::*;
(
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  data_i,
  output logic      [15:0] crc_o
);

  // lsb first, one shift per bit
  always_comb begin
    crc_o = crc_i ^ {8'h00, data_i};
    for (int b = 0; b < 8; b++) begin
      crc_o = crc_o[0] ? ((crc_o >> 1) ^ CRC_POLY) : (crc_o >> 1);
    end
  end

endmodule
`default_nettype wire

/* verilog/mbs_slave.sv */
/*
  mbs_slave: addressed command handler for bits and channel words.
  assumes: rx bytes and frame_gap_i come from a uart on core_clk_i;
  frame_gap_i pulses on the inter-frame silence, never with a byte;
  the tx side takes a byte when valid and tx_ready_i are both high.
*/
// Behaviour
// - frame opens with unit number then function; act on own or broadcast
// - bit read: function 01, address 0/0-24, count 0/1, then check bytes
// - bits 0-11 leds, 12-23 relays per channel, 24 system alarm relay
// - bit read reply: unit, 01, count 1, value 00 or ff, check bytes
// - bit write: function 05, value ff or 00, pad 0; apply and echo
// - word read: function 03, address 0/0-3, count 0/1, check bytes
// - word read reply is seven bytes: unit, 03, 02, high, low, check
// - readings are signed 16-bit, high byte sent first
// - word write: function 06, address 0-3, value; store and echo
// - unit 0: execute writes, never reply
// - requests are eight bytes, check bytes last
`timescale 1ns/1ns
`default_nettype none
module mbs_slave
  import mbs_pkg::*;
#(
  parameter int unsigned NUM_COILS = COIL_COUNT,
  parameter int unsigned NUM_CHAN  = CHAN_COUNT
)(
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [7:0]                station_id_i,
  input  wire mbs_byte_s                 rx_byte_i,
  input  wire logic                      frame_gap_i,
  input  wire logic                      tx_ready_i,
  output mbs_byte_s                      tx_o,
  output var logic [NUM_COILS-1:0]       coil_o,
  output var logic [NUM_CHAN-1:0][15:0]  reading_o
);

  localparam int CW = $clog2(NUM_COILS);
  localparam int HW = $clog2(NUM_CHAN);

  mbs_state_e       state;
  logic [7:0][7:0]  rbuf;
  logic [3:0]       rx_cnt;
  logic [15:0]      rx_crc;
  logic [3:0]       tx_idx;
  logic [3:0]       tx_ndata;
  logic [3:0]       tx_total;
  logic [15:0]      tx_crc;
  logic [15:0]      rx_crc_step;
  logic [15:0]      tx_crc_step;

  mbs_crc_step u_rx_crc (
    .crc_i  (rx_crc),
    .data_i (rx_byte_i.data),
    .crc_o  (rx_crc_step)
  );

  mbs_crc_step u_tx_crc (
    .crc_i  (tx_crc),
    .data_i (tx_o.data),
    .crc_o  (tx_crc_step)
  );

  // frame as it stands once the last byte arrives
  wire [7:0][7:0] frame = {rx_byte_i.data, rbuf[6:0]};
  wire [7:0] unit = frame[0];
  wire [7:0] func = frame[1];
  wire [7:0] ahi  = frame[2];
  wire [7:0] alo  = frame[3];
  wire [7:0] b4   = frame[4];
  wire [7:0] b5   = frame[5];

  wire rx_take   = (state == MBS_RX) && rx_byte_i.valid
                   && (rx_cnt < FRAME_LEN);
  wire last_byte = rx_take && (rx_cnt == FRAME_LEN - 4'h1);
  wire crc_ok    = (rx_crc_step == CRC_RESIDUE);
  wire bcast     = (unit == BCAST_UNIT);
  wire for_me    = bcast || (unit == station_id_i);

  wire coil_ok = (ahi == ADDR_HIGH) && (alo <= 8'(NUM_COILS - 1));
  wire chan_ok = (ahi == ADDR_HIGH) && (alo <= 8'(NUM_CHAN - 1));
  wire cnt_one = (b4 == COUNT_HIGH) && (b5 == COUNT_LOW);
  wire val_ok  = ((b4 == COIL_ON) || (b4 == COIL_OFF))
                 && (b5 == COIL_PAD);

  wire is_rd_coil = (func == FN_READ_BIT) && coil_ok && cnt_one;
  wire is_wr_coil = (func == FN_WRITE_BIT) && coil_ok && val_ok;
  wire is_rd_reg  = (func == FN_READ_WORD) && chan_ok && cnt_one;
  wire is_wr_reg  = (func == FN_WRITE_WORD) && chan_ok;

  // unknown functions and bad addresses simply match nothing
  wire accept     = last_byte && crc_ok && for_me;
  wire do_wr_coil = accept && is_wr_coil;
  wire do_wr_reg  = accept && is_wr_reg;
  wire do_rd_coil = accept && !bcast && is_rd_coil;
  wire do_rd_reg  = accept && !bcast && is_rd_reg;
  wire do_echo    = (do_wr_coil || do_wr_reg) && !bcast;
  wire start_tx   = do_rd_coil || do_rd_reg || do_echo;

  wire [CW-1:0] coil_idx = alo[CW-1:0];
  wire [HW-1:0] chan_idx = alo[HW-1:0];
  wire [7:0]  coil_byte = coil_o[coil_idx] ? COIL_ON : COIL_OFF;
  wire [15:0] sel_word  = reading_o[chan_idx];

  // next outgoing byte: stored frame, then crc low, then crc high
  wire       tx_fire = tx_o.valid && tx_ready_i;
  wire [3:0] nidx    = tx_idx + 4'h1;
  wire [7:0] nbyte   = (nidx < tx_ndata) ? rbuf[nidx[2:0]] :
                       (nidx == tx_ndata) ? tx_crc_step[7:0] :
                       tx_crc[15:8];

  // receive side; half duplex, so bytes during a reply are dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i || frame_gap_i) begin
      rx_cnt <= 4'h0;
      rx_crc <= CRC_INIT;
    end else if (rx_take) begin
      rx_cnt <= rx_cnt + 4'h1;
      rx_crc <= rx_crc_step;
    end
  end

  // reply payload overwrites the request in place
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rbuf <= '0;
    end else if (do_rd_coil) begin
      rbuf[7]   <= rx_byte_i.data;
      rbuf[2]   <= BIT_BYTES;
      rbuf[3]   <= coil_byte;
    end else if (do_rd_reg) begin
      rbuf[7]   <= rx_byte_i.data;
      rbuf[2]   <= WORD_BYTES;
      rbuf[3]   <= sel_word[15:8];
      rbuf[4]   <= sel_word[7:0];
    end else if (rx_take) begin
      rbuf[rx_cnt[2:0]] <= rx_byte_i.data;
    end
  end

  // transmit side
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state    <= MBS_RX;
      tx_o     <= '0;
      tx_idx   <= 4'h0;
      tx_ndata <= 4'h0;
      tx_total <= 4'h0;
      tx_crc   <= CRC_INIT;
    end else begin
      case (state)
        MBS_RX: begin
          if (start_tx) begin
            state      <= MBS_TX;
            tx_o.valid <= 1'b1;
            tx_o.data  <= unit;
            tx_idx     <= 4'h0;
            tx_crc     <= CRC_INIT;
            // echo resends the stored check bytes unchanged
            tx_ndata   <= do_rd_coil ? RD_BIT_DATA :
                          do_rd_reg ? RD_WORD_DATA : FRAME_LEN;
            tx_total   <= do_rd_coil ? RD_BIT_LEN :
                          do_rd_reg ? RD_WORD_LEN : FRAME_LEN;
          end
        end
        default: begin
          if (tx_fire) begin
            if (tx_idx < tx_ndata) begin
              tx_crc <= tx_crc_step;
            end
            if (nidx == tx_total) begin
              state      <= MBS_RX;
              tx_o.valid <= 1'b0;
            end else begin
              tx_o.data <= nbyte;
              tx_idx    <= nidx;
            end
          end
        end
      endcase
    end
  end

  // one flop per bit keeps each led and relay independently writable
  for (genvar i = 0; i < NUM_COILS; i++) begin : g_coil
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        coil_o[i] <= COIL_RST;
      end else if (do_wr_coil && (coil_idx == CW'(i))) begin
        coil_o[i] <= (b4 == COIL_ON);
      end
    end
  end

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        reading_o[c] <= READING_RST;
      end else if (do_wr_reg && (chan_idx == HW'(c))) begin
        reading_o[c] <= {b4, b5};
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_bad_crc;
    last_byte && !crc_ok |=> !tx_o.valid ##1 !tx_o.valid;
  endproperty
  a_bad_crc: assert property (p_bad_crc)
    else $error("reply started for bad crc");

  property p_bcast_silent;
    last_byte && bcast |=> state == MBS_RX;
  endproperty
  a_bcast_silent: assert property (p_bcast_silent)
    else $error("reply to broadcast");

  property p_foreign;
    last_byte && !for_me |=> !tx_o.valid && $stable(coil_o)
      && $stable(reading_o);
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("frame for other unit acted on");

  property p_wr_coil;
    do_wr_coil |=> coil_o[$past(coil_idx)] == ($past(b4) == COIL_ON);
  endproperty
  a_wr_coil: assert property (p_wr_coil)
    else $error("bit write not applied");

  property p_wr_reg;
    do_wr_reg |=> reading_o[$past(chan_idx)] == {$past(b4), $past(b5)};
  endproperty
  a_wr_reg: assert property (p_wr_reg)
    else $error("word write not stored");

  property p_rd_coil;
    do_rd_coil |=> tx_o.valid && tx_o.data == $past(unit)
      && tx_total == RD_BIT_LEN && rbuf[2] == BIT_BYTES;
  endproperty
  a_rd_coil: assert property (p_rd_coil)
    else $error("bad bit read reply");

  property p_rd_reg;
    do_rd_reg |=> tx_total == RD_WORD_LEN && rbuf[2] == WORD_BYTES
      && {rbuf[3], rbuf[4]} == $past(sel_word);
  endproperty
  a_rd_reg: assert property (p_rd_reg)
    else $error("bad word read reply");

  property p_echo;
    do_echo |=> tx_total == FRAME_LEN && tx_ndata == FRAME_LEN;
  endproperty
  a_echo: assert property (p_echo)
    else $error("write reply is not an echo");

  property p_bad_count;
    last_byte && func == FN_READ_BIT && !cnt_one |=> !tx_o.valid;
  endproperty
  a_bad_count: assert property (p_bad_count)
    else $error("bit read with bad count answered");

  property p_tx_hold;
    tx_o.valid && !tx_ready_i |=> tx_o.valid && $stable(tx_o.data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte dropped before taken");

  c_rd_coil: cover property (do_rd_coil ##[1:40] state == MBS_RX);
  c_rd_reg:  cover property (do_rd_reg ##[1:40] state == MBS_RX);
  c_echo:    cover property (do_echo);
  c_bcast:   cover property (do_wr_reg && bcast);

endmodule
`default_nettype wire

/* testbench/mbs_master_model.sv */
/*
  mbs_master_model: link master sending framed requests, taking replies.
  assumes: uart side of mbs_slave; drives 2 ns after the rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module mbs_master_model
  import mbs_pkg::*;
(
  input  wire logic      clk_i,
  input  wire mbs_byte_s tx_i,
  output mbs_byte_s      rx_o,
  output logic           gap_o,
  output logic           rdy_o
);
  logic [7:0] reply_q[$];
  logic       slow = 1'b0;
  logic [3:0] cnt  = 4'h0;

  initial begin
    rx_o  = '0;
    gap_o = 1'b0;
    rdy_o = 1'b1;
  end

  // slow mode stalls on about half the edges
  always @(posedge clk_i) begin
    if (tx_i.valid && rdy_o) begin
      reply_q.push_back(tx_i.data);
    end
    cnt <= cnt + 4'h1;
    rdy_o <= #2 !slow || (cnt[0] ^ cnt[2]);
  end

  // silence first, then eight bytes back to back
  task automatic send(input logic [63:0] fr);
    int i;
    @(posedge clk_i) #2;
    gap_o = 1'b1;
    @(posedge clk_i) #2;
    gap_o = 1'b0;
    for (i = 0; i < 8; i++) begin
      rx_o = '{valid: 1'b1, data: fr[63-8*i -: 8]};
      @(posedge clk_i) #2;
    end
    // released line shows no stale byte
    rx_o = '{valid: 1'b0, data: ~rx_o.data};
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
/*
  testbench: reference decoder of requests compared with mbs_slave.
  assumes: mbs_master_model on the byte side; 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sid = 8'h00;
  mbs_byte_s rxb, tx;
  logic gap, rdy;
  logic [COIL_COUNT-1:0] coil;
  logic [CHAN_COUNT-1:0][15:0] rd;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] rs = 32'h0000000c;
  logic [COIL_COUNT-1:0] m_coil = '0;
  logic [15:0] m_rd[4];
  logic [7:0] exp_q[$];

  mbs_slave dut (.core_clk_i(clk), .rst_i(rst), .station_id_i(sid),
    .rx_byte_i(rxb), .frame_gap_i(gap), .tx_ready_i(rdy), .tx_o(tx),
    .coil_o(coil), .reading_o(rd));
  mbs_master_model m (.clk_i(clk), .tx_i(tx), .rx_o(rxb), .gap_o(gap),
    .rdy_o(rdy));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // bitwise form, kept apart from the design's byte step
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic xact(input logic [7:0] u, f, ah, al, v1, v2,
                      input logic bad);
    logic [7:0] rq[$];
    logic [15:0] c;
    logic ok;
    int n;
    rq = '{u, f, ah, al, v1, v2};
    c = crc(rq) ^ {15'h0, bad};
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    ok = !bad && (u == 8'h00 || u == sid) && ah == 8'h00;
    exp_q = {};
    case (f)
      FN_READ_BIT: begin
        ok &= u != 8'h00 && al < 8'h19 && v1 == 8'h00 && v2 == 8'h01;
        if (ok) exp_q = '{u, f, 8'h01, {8{m_coil[al]}}};
      end
      FN_READ_WORD: begin
        ok &= u != 8'h00 && al < 8'h04 && v1 == 8'h00 && v2 == 8'h01;
        if (ok) exp_q = '{u, f, 8'h02, m_rd[al][15:8], m_rd[al][7:0]};
      end
      FN_WRITE_BIT: begin
        ok &= al < 8'h19 && (v1 == 8'hff || v1 == 8'h00) && v2 == 8'h00;
        if (ok) m_coil[al] = v1[0];
        if (ok) exp_q = rq;
      end
      FN_WRITE_WORD: begin
        if (ok && al < 8'h04) m_rd[al] = {v1, v2};
        if (ok && al < 8'h04) exp_q = rq;
      end
      default: ok = 1'b0;
    endcase
    if (u == 8'h00) exp_q = {};
    if (exp_q.size() inside {4, 5}) begin
      c = crc(exp_q);
      exp_q.push_back(c[7:0]);
      exp_q.push_back(c[15:8]);
    end
    n = xs();
    m.slow = n[3];
    m.reply_q = {};
    m.send({rq[0], rq[1], rq[2], rq[3], rq[4], rq[5], rq[6], rq[7]});
    repeat (2) @(posedge clk);
    for (n = 0; n < 80 && (m.reply_q.size() < exp_q.size() || tx.valid); n++)
      @(posedge clk);
    #2;
    chk(m.reply_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (i < m.reply_q.size()) chk(m.reply_q[i], exp_q[i]);
    end
    chk(coil, m_coil);
    foreach (m_rd[i]) chk(rd[i], m_rd[i]);
  endtask

  initial begin
    #2_000_000;
    failures++;
    summarize();
  end

  initial begin
    logic [7:0] b[$];
    logic [31:0] r;
    int i;
    for (i = 0; i < 4; i++) m_rd[i] = 16'h0000;
    b = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
    chk(crc(b), 32'h0a84);
    r = xs();
    sid = r[7:0] | 8'h01;
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    chk({tx.valid, coil}, 32'h0);
    foreach (m_rd[i]) chk(rd[i], 32'h0);
    xact(sid, FN_WRITE_BIT, 8'h00, 8'h18, 8'hff, 8'h00, 1'b0);
    for (i = 0; i < 30; i++) begin
      r = xs();
      xact(r[4] ? 8'h00 : sid, FN_WRITE_BIT, 8'h00, r[15:8] % 8'h19,
           {8{r[0]}}, 8'h00, 1'b0);
    end
    for (i = 0; i < 25; i++) begin
      xact(sid, FN_READ_BIT, 8'h00, i[7:0], 8'h00, 8'h01, 1'b0);
    end
    xact(sid, FN_WRITE_WORD, 8'h00, 8'h01, 8'hfe, 8'h58, 1'b0);
    for (i = 0; i < 8; i++) begin
      r = xs();
      xact(i[2] ? 8'h00 : sid, FN_WRITE_WORD, 8'h00, {6'h0, i[1:0]},
           r[7:0], r[15:8], 1'b0);
      xact(sid, FN_READ_WORD, 8'h00, {6'h0, i[1:0]}, 8'h00, 8'h01,
           1'b0);
    end
    // refused frames: nothing may change or answer
    xact(sid, FN_READ_WORD, 8'h00, 8'h00, 8'h00, 8'h01, 1'b1);
    xact(sid ^ 8'h80, FN_WRITE_BIT, 8'h00, 8'h03, 8'hff, 8'h00, 1'b0);
    xact(sid, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0);
    xact(sid, FN_WRITE_BIT, 8'h01, 8'h03, 8'hff, 8'h00, 1'b0);
    xact(sid, FN_WRITE_BIT, 8'h00, 8'h19, 8'hff, 8'h00, 1'b0);
    xact(sid, FN_WRITE_WORD, 8'h00, 8'h04, 8'h12, 8'h34, 1'b0);
    xact(sid, FN_READ_BIT, 8'h00, 8'h02, 8'h00, 8'h02, 1'b0);
    xact(sid, FN_WRITE_BIT, 8'h00, 8'h05, 8'h7f, 8'h00, 1'b0);
    xact(sid, FN_WRITE_BIT, 8'h00, 8'h05, 8'hff, 8'h01, 1'b0);
    xact(8'h00, FN_READ_WORD, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0);
    for (i = 0; i < 60; i++) begin
      r = xs();
      xact(r[1:0] == 2'b00 ? 8'h00 : sid, {5'h0, r[3], r[2], ~(r[3] & r[2])},
           {7'h0, r[7] & r[6] & r[5]}, {3'h0, r[12:8]},
           r[16] ? {8{r[17]}} : r[23:16], r[24] ? {7'h0, r[25]} : r[31:24],
           r[4] & r[5] & r[6]);
    end
    summarize();
  end
endmodule
`default_nettype wire
